// ===== dv/flash_host_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_defines.svh"

// ********
// Host on the register port
// ********
module flash_host_model (
   input  wire logic        ref_clk_i, // Clock
   output logic      [15:0] addr_o,    // Address
   output logic      [15:0] wdata_o,   // Write data
   output logic             wr_o,      // Write strobe
   output logic             rd_o       // Read strobe
);
   initial begin
      addr_o = 16'h0000;
      wdata_o = 16'h0000;
      wr_o = 1'b0;
      rd_o = 1'b0;
   end

   // Extra edge per access, so no strobe is assigned twice in a step
   task automatic access(input logic [15:0] a, input logic [15:0] d, input logic w);
      @(posedge ref_clk_i);
      addr_o <= a;
      wdata_o <= d;
      wr_o <= w;
      rd_o <= !w;
      @(posedge ref_clk_i);
      wr_o <= 1'b0;
      rd_o <= 1'b0;
      wdata_o <= ~d; // Idle bus shows no stale data
   endtask : access

   // Buffer RAM lies outside this block; the spare-area fill stays with the caller
   task automatic command(input logic [15:0] code);
      access(`OFS_OP_STATUS, 16'h0000, 1'b1);
      access(`OFS_COMMAND, code, 1'b1);
   endtask : command
endmodule : flash_host_model
`default_nettype wire

// ===== dv/flash_regs_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none

// ********
// Port checks
// ********
module flash_regs_checker (
   input wire logic        ref_clk_i,      // Clock
   input wire logic        sys_rst_i,      // Reset
   input wire logic [15:0] addr_i,         // Address
   input wire logic [15:0] wdata_i,        // Write data
   input wire logic        wr_i,           // Write strobe
   input wire logic        rd_i,           // Read strobe
   input wire logic [15:0] rdata_o,        // Read data
   input wire logic        irq_o,          // Interrupt
   input wire logic        ready_o,        // Ready
   input wire logic        busy_o,         // Busy
   input wire logic        core_reset_o,   // Core reset
   input wire logic        buf_active_o,   // Transfer active
   input wire logic        buf_boot_sel_o, // Boot select
   input wire logic        buf_half_o,     // Data half
   input wire logic [1:0]  buf_sector_o    // Sector
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);

   a_rsvd_read: assert property (
      rd_i && addr_i inside {16'hF104, 16'hF105, 16'hF106} |=> rdata_o == 16'h0000)
      else $error("reserved read not zero");
   a_field_width: assert property (
      rd_i && (addr_i == 16'hF103 || addr_i == 16'hF107) |=> rdata_o[15:8] == 8'h00)
      else $error("upper bits not zero");
   a_dest_store: assert property (
      wr_i && addr_i == 16'hF103 ##2 rd_i && addr_i == 16'hF103
      |=> rdata_o[7:0] == $past(wdata_i[7:0], 3)) else $error("dest not stored");
   a_sector_step: assert property (
      buf_active_o && $past(buf_active_o) && !buf_boot_sel_o && $changed(buf_sector_o)
      |-> buf_sector_o == $past(buf_sector_o) + 2'h1) else $error("sector step wrong");
   a_sel_hold: assert property (
      buf_active_o && $past(buf_active_o) |-> $stable(buf_boot_sel_o) && $stable(buf_half_o))
      else $error("select moved");
   a_boot_sector: assert property (
      buf_active_o && buf_boot_sel_o |-> !buf_sector_o[1]) else $error("boot sector range");
   a_load_start: assert property (
      wr_i && addr_i == 16'hF220 && wdata_i == 16'h0000 && !busy_o |-> ##[1:2] busy_o)
      else $error("load not started");
   a_ready_back: assert property (
      $fell(busy_o) |-> ##[0:1] ready_o) else $error("ready not back");
   a_core_pulse: assert property (
      core_reset_o |=> !core_reset_o) else $error("core reset too long");
   a_read_clear: assert property (
      !rd_i |=> rdata_o == 16'h0000) else $error("read data lingers");

   c_xfer: cover property ($fell(buf_active_o));
   c_core: cover property (core_reset_o);
   c_irq: cover property ($rose(irq_o));
endmodule : flash_regs_checker

bind flash_command_address_regs flash_regs_checker u_checker (.ref_clk_i, .sys_rst_i,
   .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .irq_o, .ready_o, .busy_o, .core_reset_o,
   .buf_active_o, .buf_boot_sel_o, .buf_half_o, .buf_sector_o);
`default_nettype wire

// ===== dv/tb_flash_command_address_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_defines.svh"

module tb_flash_command_address_regs;
   localparam logic [15:0] ADR [7] = '{16'hF103, 16'hF104, 16'hF105, 16'hF106, 16'hF107,
                                       16'hF200, 16'h1234};
   localparam logic [15:0] RBK [7] = '{16'h00FF, 16'h0000, 16'h0000, 16'h0000, 16'h00FF,
                                       16'h0F03, 16'h0000};
   localparam logic [15:0] XC [5]  = '{16'h0000, 16'h0013, 16'h0080, 16'h001A, 16'h001B};
   localparam logic [15:0] SC [10] = '{16'h0023, 16'h002A, 16'h002C, 16'h0071, 16'h0094,
                                       16'h0095, 16'h00B0, 16'h0030, 16'h0065, 16'h00F0};
   logic        ref_clk_i  = 1'b0;
   logic        sys_rst_i  = 1'b1;
   logic        rd_seen    = 1'b0;
   wire  [15:0] addr, wdata, rdata;
   wire         wr, rd, irq, ready, busy, act, boot, half, crst;
   int          crst_cnt   = 0;
   wire  [1:0]  sect;
   int          fail_count = 0;
   int          tests_run  = 0;
   int          seed       = 10245;
   logic [15:0] exp_q[$];

   always #25 ref_clk_i = ~ref_clk_i;

   flash_host_model host (.ref_clk_i(ref_clk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr),
      .rd_o(rd));
   flash_command_address_regs dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr),
      .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .irq_o(irq), .ready_o(ready),
      .busy_o(busy), .core_reset_o(crst), .buf_active_o(act), .buf_boot_sel_o(boot),
      .buf_half_o(half), .buf_sector_o(sect));

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : check

   task automatic test_done;
      if (fail_count == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : test_done

   task automatic rd_chk(input logic [15:0] a, input logic [15:0] e);
      exp_q.push_back(e);
      host.access(a, 16'h0000, 1'b0);
   endtask : rd_chk

   // Read data stand only in the cycle after the strobe
   always @(posedge ref_clk_i) begin
      rd_seen <= rd;
      if (crst === 1'b1) begin
         crst_cnt++;
      end
      if (rd_seen) begin
         check(rdata, exp_q.pop_front());
      end
   end

   task automatic wait_idle;
      int n;
      n = 0;
      repeat (3) @(posedge ref_clk_i);
      while ((busy !== 1'b0 || ready !== 1'b1) && n < 500) begin
         @(posedge ref_clk_i);
         n++;
      end
      if (n >= 500) begin
         fail_count++;
         test_done();
      end
   endtask : wait_idle

   task automatic xfer(input logic [15:0] c, input logic [3:0] sec_adr,
                       input logic [1:0] sec_num, input logic m);
      int k;
      logic [1:0] s;
      k = 0;
      host.access(`OFS_IRQ_MASK, {15'h0, m}, 1'b1);
      host.access(`OFS_BUFFER_SELECT, {4'h0, sec_adr, 6'h00, sec_num}, 1'b1);
      rd_chk(`OFS_BUFFER_SELECT, {4'h0, sec_adr, 6'h00, sec_num});
      host.command(c);
      for (int t = 0; t < 300 && (k == 0 || act === 1'b1); t++) begin
         @(posedge ref_clk_i);
         if (act === 1'b1) begin
            s = sec_adr[1:0] + 2'(k / 16);
            if (k % 16 == 8) begin
               check({12'h0, boot, half, sect},
                     {12'h0, sec_adr[3:2], sec_adr[3] ? {1'b0, s[0]} : s});
            end
            k++;
         end
      end
      check(16'(k), 16'(16 * ((sec_num == 2'h0) ? 4 : sec_num)));
      wait_idle();
      rd_chk(`OFS_OP_STATUS, 16'h0001);
      rd_chk(`OFS_IRQ_STATUS, 16'h0001);
      check({15'h0, irq}, {15'h0, m});
      host.access(`OFS_IRQ_STATUS, 16'h0007, 1'b1);
      repeat (2) @(posedge ref_clk_i);
      check({15'h0, irq}, 16'h0000);
   endtask : xfer

   initial begin
      repeat (10) @(posedge ref_clk_i);
      sys_rst_i <= 1'b0;
      rd_chk(`OFS_OP_STATUS, 16'h0001);
      rd_chk(`OFS_COMMAND, 16'h0000);
      for (int i = 0; i < 7; i++) begin
         rd_chk(ADR[i], 16'h0000);
         host.access(ADR[i], 16'hFFFF, 1'b1);
         rd_chk(ADR[i], RBK[i]);
      end
      xfer(16'h0000, 4'hD, 2'h0, 1'b1);
      xfer(16'h0000, 4'h7, 2'h0, 1'b0);
      for (int i = 0; i < 5; i++) begin
         xfer(XC[i], 4'($random(seed)), 2'($random(seed)), i[0]);
      end
      for (int i = 0; i < 10; i++) begin
         host.command(SC[i]);
         wait_idle();
         rd_chk(`OFS_COMMAND, SC[i]);
         rd_chk(`OFS_OP_STATUS, 16'h0001);
         host.access(`OFS_IRQ_STATUS, 16'h0007, 1'b1);
      end
      // Busy with a load: erase refused, core reset taken
      host.access(`OFS_BUFFER_SELECT, 16'h0000, 1'b1);
      host.command(`CMD_LOAD_MAIN);
      host.command(`CMD_BLOCK_ERASE);
      rd_chk(`OFS_COMMAND, `CMD_LOAD_MAIN);
      rd_chk(`OFS_IRQ_STATUS, 16'h0002);
      host.command(`CMD_CORE_RESET);
      wait_idle();
      rd_chk(`OFS_COMMAND, `CMD_CORE_RESET);
      host.access(`OFS_IRQ_STATUS, 16'h0007, 1'b1);
      // Busy with a lock: even core reset refused
      host.command(`CMD_LOCK);
      host.access(`OFS_COMMAND, `CMD_CORE_RESET, 1'b1);
      wait_idle();
      rd_chk(`OFS_COMMAND, `CMD_LOCK);
      rd_chk(`OFS_IRQ_STATUS, 16'h0003);
      // Unknown code while idle: refused, command register keeps the lock code
      host.access(`OFS_IRQ_STATUS, 16'h0007, 1'b1);
      host.command(16'($random(seed)) | 16'h0100);
      rd_chk(`OFS_COMMAND, `CMD_LOCK);
      rd_chk(`OFS_IRQ_STATUS, 16'h0002);
      host.access(`OFS_COPYBACK_DEST, 16'($random(seed)), 1'b1);
      host.access(`OFS_IRQ_MASK, 16'h0007, 1'b1);
      host.command(`CMD_HOT_RESET);
      wait_idle();
      rd_chk(`OFS_COPYBACK_DEST, 16'h0000);
      rd_chk(`OFS_IRQ_MASK, 16'h0000);
      rd_chk(`OFS_COMMAND, 16'h0000);
      repeat (3) @(posedge ref_clk_i);
      check(16'(crst_cnt), 16'h0003);
      check(16'(exp_q.size()), 16'h0000);
      test_done();
   end
endmodule : tb_flash_command_address_regs
`default_nettype wire

// ===== rtl/flash_cmd_defines.svh
`ifndef FLASH_CMD_DEFINES_SVH
`define FLASH_CMD_DEFINES_SVH

// ****************************************
// Register offsets (16-bit word addresses)
// ****************************************
`define OFS_COPYBACK_DEST     16'hF103
`define OFS_RSVD_FIVE         16'hF104
`define OFS_RSVD_SIX          16'hF105
`define OFS_RSVD_SEVEN        16'hF106
`define OFS_START_PAGE_SECTOR 16'hF107
`define OFS_BUFFER_SELECT     16'hF200
`define OFS_COMMAND           16'hF220
`define OFS_OP_STATUS         16'hF230
`define OFS_IRQ_STATUS        16'hF231
`define OFS_IRQ_MASK          16'hF232

// ****************************************
// Field positions
// ****************************************
`define SECTOR_LSB  0
`define SECTOR_MSB  1
`define PAGE_LSB    2
`define PAGE_MSB    7
`define BUF_COUNT_LSB 0
`define BUF_COUNT_MSB 1
`define BUF_ADDR_LSB  8
`define BUF_ADDR_MSB  11

// ****************************************
// Reset values
// ****************************************
`define RST_REG16   16'h0000
`define RST_IRQ     3'h0

// ****************************************
// Command codes
// ****************************************
`define CMD_LOAD_MAIN     16'h0000
`define CMD_LOAD_SPARE    16'h0013
`define CMD_PROG_ALL      16'h0080
`define CMD_PROG_SPARE    16'h001A
`define CMD_COPYBACK      16'h001B
`define CMD_UNLOCK        16'h0023
`define CMD_LOCK          16'h002A
`define CMD_LOCK_TIGHT    16'h002C
`define CMD_ERASE_VERIFY  16'h0071
`define CMD_BLOCK_ERASE   16'h0094
`define CMD_MULTI_ERASE   16'h0095
`define CMD_ERASE_SUSPEND 16'h00B0
`define CMD_ERASE_RESUME  16'h0030
`define CMD_CORE_RESET    16'h00F0
`define CMD_HOT_RESET     16'h00F3
`define CMD_OTP_ACCESS    16'h0065

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS     50
`define SECTOR_TIME_NS    800
`define SECTOR_CYCLES     ((`SECTOR_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SHORT_OP_NS       200
`define SHORT_OP_CYCLES   ((`SHORT_OP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== rtl/flash_cmd_pkg.sv
package flash_cmd_pkg;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_XFER  = 4'b0010,
      ST_SHORT = 4'b0100,
      ST_DONE  = 4'b1000
   } op_state_t;

   typedef enum logic [2:0] {
      OP_NONE  = 3'h0,
      OP_XFER  = 3'h1,
      OP_ABORT = 3'h2,
      OP_PROT  = 3'h3,
      OP_OTHER = 3'h4
   } op_class_t;

endpackage : flash_cmd_pkg

// ===== rtl/flash_command_address_regs.sv
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_defines.svh"

module flash_command_address_regs
   import flash_cmd_pkg::*;
(
   input  wire logic        ref_clk_i,       // 20 MHz clock
   input  wire logic        sys_rst_i,       // Sync reset, active high
   input  wire logic [15:0] addr_i,          // Register word address
   input  wire logic [15:0] wdata_i,         // Write data
   input  wire logic        wr_i,            // Write strobe
   input  wire logic        rd_i,            // Read strobe
   output logic      [15:0] rdata_o,         // Read data, cycle after strobe
   output logic             irq_o,           // Level interrupt
   output logic             ready_o,         // Ready indication (1 = ready)
   output logic             busy_o,          // Operation in progress
   output logic             core_reset_o,    // Pulse: core reset
   output logic             buf_active_o,    // Buffer sector access valid
   output logic             buf_boot_sel_o,  // 1 = boot RAM, 0 = data RAM
   output logic             buf_half_o,      // Data RAM half
   output logic      [1:0]  buf_sector_o     // Sector inside selected RAM
);

   // ****************************************
   // Registers
   // ****************************************
   logic [5:0]  copyback_page;
   logic [1:0]  copyback_sector;
   logic [5:0]  start_page;
   logic [1:0]  start_sector;
   logic [3:0]  buffer_sector_address;
   logic [1:0]  buffer_sector_count;
   logic [15:0] command;
   logic        ready;
   logic [2:0]  irq_status;
   logic [2:0]  irq_mask;
   op_state_t   state;
   op_class_t   op_class;
   logic [4:0]  cyc_cnt;
   logic [2:0]  sectors_left;
   logic [1:0]  step_sector;
   logic        hot_reset;

   // ****************************************
   // Address decode
   // ****************************************
   wire hit_copyback = (addr_i == `OFS_COPYBACK_DEST);
   wire hit_start    = (addr_i == `OFS_START_PAGE_SECTOR);
   wire hit_buffer   = (addr_i == `OFS_BUFFER_SELECT);
   wire hit_command  = (addr_i == `OFS_COMMAND);
   wire hit_status   = (addr_i == `OFS_OP_STATUS);
   wire hit_irq_st   = (addr_i == `OFS_IRQ_STATUS);
   wire hit_irq_mask = (addr_i == `OFS_IRQ_MASK);

   wire wr_copyback  = wr_i & hit_copyback;
   wire wr_start     = wr_i & hit_start;
   wire wr_buffer    = wr_i & hit_buffer;
   wire wr_command   = wr_i & hit_command;
   wire wr_status    = wr_i & hit_status;
   wire wr_irq_st    = wr_i & hit_irq_st;
   wire wr_irq_mask  = wr_i & hit_irq_mask;

   // ****************************************
   // Command classification
   // ****************************************
   wire [15:0] c = wdata_i;
   wire is_xfer = (c == `CMD_LOAD_MAIN) | (c == `CMD_LOAD_SPARE)
                | (c == `CMD_PROG_ALL) | (c == `CMD_PROG_SPARE)
                | (c == `CMD_COPYBACK);
   wire is_prot = (c == `CMD_UNLOCK) | (c == `CMD_LOCK)
                | (c == `CMD_LOCK_TIGHT);
   wire is_long = (c == `CMD_ERASE_VERIFY) | (c == `CMD_BLOCK_ERASE)
                | (c == `CMD_MULTI_ERASE) | (c == `CMD_ERASE_RESUME)
                | (c == `CMD_OTP_ACCESS);
   wire is_susp = (c == `CMD_ERASE_SUSPEND);
   wire is_core = (c == `CMD_CORE_RESET);
   wire is_hot  = (c == `CMD_HOT_RESET);
   wire is_known = is_xfer | is_prot | is_long | is_susp | is_core | is_hot;

   // Abortable ops accept only the two reset codes; others accept nothing
   wire op_idle     = (state == ST_IDLE) | (state == ST_DONE);
   wire abortable   = (op_class == OP_XFER) | (op_class == OP_OTHER);
   wire abort_ok    = abortable & (is_core | is_hot);
   wire cmd_take    = wr_command & is_known & (op_idle | (~op_idle & abort_ok));
   wire cmd_reject  = wr_command & ~cmd_take;
   wire take_hot    = cmd_take & is_hot;
   wire take_core   = cmd_take & is_core;
   wire take_xfer   = cmd_take & is_xfer;
   wire take_plain  = cmd_take & (is_prot | is_long | is_susp);

   // Sector count 00 means four
   wire [2:0] count_sectors = (buffer_sector_count == 2'h0) ? 3'h4
                            : {1'b0, buffer_sector_count};

   wire [4:0] sector_cycles = 5'(`SECTOR_CYCLES);
   wire [4:0] short_cycles  = 5'(`SHORT_OP_CYCLES);
   wire       cnt_done      = (cyc_cnt == 5'h01);
   wire       last_sector   = (sectors_left == 3'h1);
   wire       op_finish     = ((state == ST_XFER) & cnt_done & last_sector)
                            | ((state == ST_SHORT) & cnt_done);

   // ****************************************
   // Interrupt events: done, reject, core reset
   // ****************************************
   wire [2:0] irq_event = {take_core, cmd_reject, op_finish};
   wire [2:0] next_irq_status = irq_event
                              | (irq_status & ~(wr_irq_st ? wdata_i[2:0] : 3'h0));

   // ****************************************
   // Read mux
   // ****************************************
   wire [15:0] rd_copyback = {8'h00, copyback_page, copyback_sector};
   wire [15:0] rd_start    = {8'h00, start_page, start_sector};
   wire [15:0] rd_buffer   = {4'h0, buffer_sector_address, 6'h00, buffer_sector_count};
   wire [15:0] rd_status   = {14'h0000, busy_o, ready};
   wire [15:0] next_rdata  = hit_copyback ? rd_copyback
                           : hit_start    ? rd_start
                           : hit_buffer   ? rd_buffer
                           : hit_command  ? command
                           : hit_status   ? rd_status
                           : hit_irq_st   ? {13'h0000, irq_status}
                           : hit_irq_mask ? {13'h0000, irq_mask}
                           : 16'h0000;

   wire soft_rst = sys_rst_i | hot_reset;

   // ****************************************
   // Address registers
   // ****************************************
   always_ff @(posedge ref_clk_i) begin
      if (soft_rst) begin
         copyback_page   <= 6'h00;
         copyback_sector <= 2'h0;
      end else if (wr_copyback) begin
         copyback_page   <= wdata_i[`PAGE_MSB:`PAGE_LSB];
         copyback_sector <= wdata_i[`SECTOR_MSB:`SECTOR_LSB];
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (soft_rst) begin
         start_page   <= 6'h00;
         start_sector <= 2'h0;
      end else if (wr_start) begin
         start_page   <= wdata_i[`PAGE_MSB:`PAGE_LSB];
         start_sector <= wdata_i[`SECTOR_MSB:`SECTOR_LSB];
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (soft_rst) begin
         buffer_sector_address <= 4'h0;
         buffer_sector_count   <= 2'h0;
      end else if (wr_buffer) begin
         buffer_sector_address <= wdata_i[`BUF_ADDR_MSB:`BUF_ADDR_LSB];
         buffer_sector_count   <= wdata_i[`BUF_COUNT_MSB:`BUF_COUNT_LSB];
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (soft_rst) begin
         command <= `RST_REG16;
      end else if (cmd_take) begin
         command <= wdata_i;
      end
   end

   // ****************************************
   // Ready indication
   // ****************************************
   // Host clears to busy before writing a command; finish sets ready again
   always_ff @(posedge ref_clk_i) begin
      if (soft_rst) begin
         ready <= 1'b1;
      end else if (op_finish) begin
         ready <= 1'b1;
      end else if (wr_status & ~wdata_i[0]) begin
         ready <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (soft_rst) begin
         irq_status <= `RST_IRQ;
         irq_mask   <= `RST_IRQ;
      end else begin
         irq_status <= next_irq_status;
         if (wr_irq_mask) begin
            irq_mask <= wdata_i[2:0];
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         hot_reset <= 1'b0;
      end else begin
         hot_reset <= take_hot;
      end
   end

   // ****************************************
   // Operation sequencer
   // ****************************************
   always_ff @(posedge ref_clk_i) begin
      if (soft_rst) begin
         state        <= ST_IDLE;
         op_class     <= OP_NONE;
         cyc_cnt      <= 5'h00;
         sectors_left <= 3'h0;
         step_sector  <= 2'h0;
      end else if (take_core) begin
         state    <= ST_SHORT;
         op_class <= OP_ABORT;
         cyc_cnt  <= short_cycles;
      end else if (take_xfer) begin
         state        <= ST_XFER;
         op_class     <= OP_XFER;
         cyc_cnt      <= sector_cycles;
         sectors_left <= count_sectors;
         step_sector  <= buffer_sector_address[1:0];
      end else if (take_plain) begin
         state    <= ST_SHORT;
         op_class <= (is_long) ? OP_OTHER : OP_PROT;
         cyc_cnt  <= short_cycles;
      end else begin
         case (state)
            ST_IDLE: begin
               state <= ST_IDLE;
            end
            ST_XFER: begin
               if (cnt_done) begin
                  if (last_sector) begin
                     state <= ST_DONE;
                  end else begin
                     sectors_left <= sectors_left - 3'h1;
                     step_sector  <= step_sector + 2'h1;
                     cyc_cnt      <= sector_cycles;
                  end
               end else begin
                  cyc_cnt <= cyc_cnt - 5'h01;
               end
            end
            ST_SHORT: begin
               if (cnt_done) begin
                  state <= ST_DONE;
               end else begin
                  cyc_cnt <= cyc_cnt - 5'h01;
               end
            end
            ST_DONE: begin
               state    <= ST_IDLE;
               op_class <= OP_NONE;
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // ****************************************
   // Registered outputs
   // ****************************************
   wire next_buf_active = (state == ST_XFER);
   // Boot RAM has two sectors, so only bit 0 matters there
   wire [1:0] next_buf_sector = buffer_sector_address[3] ? {1'b0, step_sector[0]}
                                                         : step_sector;

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         rdata_o        <= 16'h0000;
         irq_o          <= 1'b0;
         ready_o        <= 1'b1;
         busy_o         <= 1'b0;
         core_reset_o   <= 1'b0;
         buf_active_o   <= 1'b0;
         buf_boot_sel_o <= 1'b0;
         buf_half_o     <= 1'b0;
         buf_sector_o   <= 2'h0;
      end else begin
         rdata_o        <= rd_i ? next_rdata : 16'h0000;
         irq_o          <= |(next_irq_status & irq_mask);
         ready_o        <= ready;
         busy_o         <= ~op_idle;
         core_reset_o   <= take_core | take_hot;
         buf_active_o   <= next_buf_active;
         buf_boot_sel_o <= buffer_sector_address[3];
         buf_half_o     <= buffer_sector_address[2];
         buf_sector_o   <= next_buf_sector;
      end
   end

endmodule : flash_command_address_regs
`default_nettype wire
